//--- mbmmu_consts.vh
// Constants of the mode based access-control unit: offsets, fields, codes, map.
// Included by every design file of the unit; holds definitions only.
`ifndef MBMMU_CONSTS_VH
`define MBMMU_CONSTS_VH

// Register offsets (byte addresses on the 12-bit AXI4-Lite window)
`define MBM_OFF_CTRL 12'h000
`define MBM_OFF_TPTR 12'h004
`define MBM_OFF_FWL 12'h008
`define MBM_OFF_FWH 12'h00c
`define MBM_OFF_XBL 12'h010
`define MBM_OFF_XBH 12'h014
`define MBM_OFF_XSL 12'h018
`define MBM_OFF_XSH 12'h01c
`define MBM_OFF_STAT 12'h020
`define MBM_OFF_SEG 12'h400
`define MBM_SEG_RIGHTS 2'h0
`define MBM_SEG_FIRST 2'h1
`define MBM_SEG_LAST 2'h2
`define MBM_SEG_OFFS 2'h3

// Reset values
`define MBM_RST_CTRL 2'h1
`define MBM_RST_TPTR 20'h00000
`define MBM_RST_FW 8'h00
`define MBM_RST_XW 8'h00

// Control and status fields
`define MBM_CTRL_BOOT 0
`define MBM_CTRL_TEST 1
`define MBM_STAT_DENY 16

// Segment rights word fields
`define MBM_RT_RD 0
`define MBM_RT_WR 1
`define MBM_RT_EX 2
`define MBM_RT_HWR 3
`define MBM_RT_HWW 4

// Program status high fields
`define MBM_PROGRAM_STATUS_HIGH_CL 3
`define MBM_PROGRAM_STATUS_HIGH_SYS 4

// CPU modes
`define MBM_MODE_BOOT 3'h0
`define MBM_MODE_TEST 3'h1
`define MBM_MODE_CLOS 3'h2
`define MBM_MODE_SYS 3'h3
`define MBM_MODE_USER 3'h4

// Memory operations
`define MBM_OP_RD 2'h0
`define MBM_OP_WR 2'h1
`define MBM_OP_EX 2'h2

// Register groups
`define MBM_GRP_CPU 3'h0
`define MBM_GRP_SEGCFG 3'h1
`define MBM_GRP_SYSM 3'h2
`define MBM_GRP_FWCFG 3'h3
`define MBM_GRP_CLOS 3'h4
`define MBM_GRP_TEST 3'h5
`define MBM_GRP_HW 3'h6

// Memory regions
`define MBM_RG_TROM 3'h0
`define MBM_RG_AROM 3'h1
`define MBM_RG_CLEE 3'h2
`define MBM_RG_AEE 3'h3
`define MBM_RG_CLRAM 3'h4
`define MBM_RG_ARAM 3'h5
`define MBM_RG_MFG 3'h6
`define MBM_RG_NONE 3'h7

// Physical memory map
`define MBM_ROM_BASE 20'h00000
`define MBM_TROM_END 20'h07fff
`define MBM_ROM_END 20'h3ffff
`define MBM_EE_BASE 20'h40000
`define MBM_EE_CL_END 20'h40fff
`define MBM_EE_MFG_END 20'h4007f
`define MBM_EE_END 20'h63fff
`define MBM_RAM_BASE 20'h80000
`define MBM_RAM_CL_END 20'h800ff
`define MBM_RAM_END 20'h81fff

`endif

//--- mbmmu_seg_match.v
// One segment table entry matcher: range hit, operation rights, relocation.
// Assumes a virtual address and operation that are stable for the cycle.
`timescale 1ns/1ps
`include "mbmmu_consts.vh"
module mbmmu_seg_match #(
  parameter VA_W = 16,
  parameter PA_W = 20
) (
  input wire [7:0] rights_i,
  input wire [VA_W-1:0] first_i,
  input wire [VA_W-1:0] last_i,
  input wire [PA_W-1:0] offs_i,
  input wire [VA_W-1:0] vaddr_i,
  input wire [1:0] op_i,
  output wire hit_o,
  output wire allow_o,
  output wire [PA_W-1:0] paddr_o
);
  wire enabled;
  // Entry with no memory right is disabled and matches nothing
  assign enabled = rights_i[`MBM_RT_RD] | rights_i[`MBM_RT_WR] | rights_i[`MBM_RT_EX];
  assign hit_o = enabled && (vaddr_i >= first_i) && (vaddr_i <= last_i);
  // Each operation checked against its own right
  assign allow_o = (op_i == `MBM_OP_RD) ? rights_i[`MBM_RT_RD] :
                   (op_i == `MBM_OP_WR) ? rights_i[`MBM_RT_WR] :
                   (op_i == `MBM_OP_EX) ? rights_i[`MBM_RT_EX] : 1'b0;
  assign paddr_o = {{(PA_W-VA_W){1'b0}}, vaddr_i} + offs_i;
endmodule // mbmmu_seg_match

//--- mbmmu_sfr_guard.v
// Grant decision for one special function register access.
// Assumes mode, group and rights are stable for the cycle of the request.
`timescale 1ns/1ps
`include "mbmmu_consts.vh"
module mbmmu_sfr_guard (
  input wire [2:0] mode_i,
  input wire [2:0] group_i,
  input wire we_i,
  input wire status_reg_i,
  input wire [2:0] hw_idx_i,
  input wire [7:0] seg_rights_i,
  input wire [7:0] fw_rd_i,
  input wire [7:0] fw_wr_i,
  output reg grant_o
);
  reg hw_ok;
  always @* begin
    hw_ok = 1'b0;
    grant_o = 1'b0;
    if (mode_i == `MBM_MODE_USER) begin
      hw_ok = we_i ? seg_rights_i[`MBM_RT_HWW] : seg_rights_i[`MBM_RT_HWR];
    end else begin
      hw_ok = we_i ? fw_wr_i[hw_idx_i] : fw_rd_i[hw_idx_i];
    end
    // Register group and mode decide the grant
    case (group_i)
      `MBM_GRP_CPU: grant_o = 1'b1;
      `MBM_GRP_SEGCFG: grant_o = (mode_i == `MBM_MODE_SYS);
      `MBM_GRP_SYSM: begin
        case (mode_i)
          `MBM_MODE_BOOT, `MBM_MODE_TEST, `MBM_MODE_SYS: grant_o = 1'b1;
          `MBM_MODE_CLOS, `MBM_MODE_USER: grant_o = status_reg_i & ~we_i;
          default: grant_o = 1'b0;
        endcase
      end
      `MBM_GRP_FWCFG: begin
        case (mode_i)
          `MBM_MODE_BOOT, `MBM_MODE_TEST, `MBM_MODE_SYS: grant_o = 1'b1;
          `MBM_MODE_CLOS: grant_o = ~we_i;
          default: grant_o = 1'b0;
        endcase
      end
      `MBM_GRP_CLOS: grant_o = (mode_i == `MBM_MODE_BOOT) || (mode_i == `MBM_MODE_TEST) ||
                               (mode_i == `MBM_MODE_CLOS);
      `MBM_GRP_TEST: grant_o = (mode_i == `MBM_MODE_BOOT) || (mode_i == `MBM_MODE_TEST);
      `MBM_GRP_HW: begin
        case (mode_i)
          `MBM_MODE_BOOT, `MBM_MODE_TEST, `MBM_MODE_SYS: grant_o = 1'b1;
          `MBM_MODE_CLOS, `MBM_MODE_USER: grant_o = hw_ok;
          default: grant_o = 1'b0;
        endcase
      end
      default: grant_o = 1'b0;
    endcase
  end
endmodule // mbmmu_sfr_guard

//--- mbmmu_top.v
// Mode based translation and access-control unit with its AXI4-Lite register slave.
// Assumes the CPU holds each request for one cycle and the register file answers
// a read strobe with data in the same cycle.
`timescale 1ns/1ps
`include "mbmmu_consts.vh"
module mbmmu_top #(
  parameter NSEG = 64,
  parameter VA_W = 16,
  parameter PA_W = 20,
  parameter CL_MODE_EN = 1
) (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [7:0] program_status_high_i,
  input wire mem_req_i,
  input wire [1:0] mem_op_i,
  input wire [VA_W-1:0] mem_vaddr_i,
  output reg mem_gnt_o,
  output reg mem_deny_o,
  output reg [PA_W-1:0] mem_paddr_o,
  output reg [1:0] mem_op_o,
  input wire sfr_req_i,
  input wire sfr_we_i,
  input wire [2:0] sfr_group_i,
  input wire [2:0] sfr_hw_idx_i,
  input wire sfr_status_reg_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_i,
  output reg sfr_re_o,
  output reg sfr_we_o,
  output reg [7:0] sfr_wdata_o,
  output reg [7:0] cpu_rdata_o,
  output reg sfr_done_o,
  output reg sfr_deny_o,
  output reg [2:0] cpu_mode_o,
  output reg [PA_W-1:0] table_ptr_o
);
  reg [1:0] ctrl_reg;
  reg [7:0] fwl_reg, fwh_reg, xbl_reg, xbh_reg, xsl_reg, xsh_reg;
  reg deny_reg;
  reg [5:0] act_seg_reg;
  reg [7:0] seg_rights [0:NSEG-1];
  reg [VA_W-1:0] seg_first [0:NSEG-1];
  reg [VA_W-1:0] seg_last [0:NSEG-1];
  reg [PA_W-1:0] seg_offs [0:NSEG-1];
  reg [11:0] awaddr_reg;
  reg aw_held, w_held;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg rd_pend, rd_gnt_reg;
  reg [2:0] mode;
  integer k, j;

  // Mode from internal bits and status high
  always @* begin
    if (ctrl_reg[`MBM_CTRL_TEST])
      mode = `MBM_MODE_TEST;
    else if (ctrl_reg[`MBM_CTRL_BOOT])
      mode = `MBM_MODE_BOOT;
    else if ((CL_MODE_EN != 0) && program_status_high_i[`MBM_PROGRAM_STATUS_HIGH_CL])
      mode = `MBM_MODE_CLOS;
    else if (program_status_high_i[`MBM_PROGRAM_STATUS_HIGH_SYS])
      mode = `MBM_MODE_SYS;
    else
      mode = `MBM_MODE_USER;
  end

  // Segment matchers, lowest index wins
  wire [NSEG-1:0] hit, allow;
  wire [PA_W-1:0] seg_pa [0:NSEG-1];
  genvar g;
  generate
    for (g = 0; g < NSEG; g = g + 1) begin : seg_gen
      mbmmu_seg_match #(.VA_W(VA_W), .PA_W(PA_W)) u_match (
        .rights_i(seg_rights[g]),
        .first_i(seg_first[g]),
        .last_i(seg_last[g]),
        .offs_i(seg_offs[g]),
        .vaddr_i(mem_vaddr_i),
        .op_i(mem_op_i),
        .hit_o(hit[g]),
        .allow_o(allow[g]),
        .paddr_o(seg_pa[g])
      );
    end
  endgenerate

  reg any_hit, hit_allow;
  reg [5:0] hit_idx;
  reg [PA_W-1:0] paddr;
  always @* begin
    any_hit = 1'b0;
    hit_allow = 1'b0;
    hit_idx = 6'h00;
    paddr = {{(PA_W-VA_W){1'b0}}, mem_vaddr_i};
    for (k = NSEG - 1; k >= 0; k = k - 1) begin
      if (hit[k]) begin
        any_hit = 1'b1;
        hit_allow = allow[k];
        hit_idx = k[5:0];
        paddr = seg_pa[k];
      end
    end
  end

  // Region of a physical address
  function [2:0] region;
    input [PA_W-1:0] pa;
    begin
      if (pa <= `MBM_TROM_END)
        region = `MBM_RG_TROM;
      else if (pa <= `MBM_ROM_END)
        region = `MBM_RG_AROM;
      else if ((pa >= `MBM_EE_BASE) && (pa <= `MBM_EE_END)) begin
        if (CL_MODE_EN == 0)
          region = (pa <= `MBM_EE_MFG_END) ? `MBM_RG_MFG : `MBM_RG_AEE;
        else
          region = (pa <= `MBM_EE_CL_END) ? `MBM_RG_CLEE : `MBM_RG_AEE;
      end else if ((pa >= `MBM_RAM_BASE) && (pa <= `MBM_RAM_END)) begin
        if ((CL_MODE_EN != 0) && (pa <= `MBM_RAM_CL_END))
          region = `MBM_RG_CLRAM;
        else
          region = `MBM_RG_ARAM;
      end else
        region = `MBM_RG_NONE;
    end
  endfunction

  wire [2:0] rg = region(paddr);
  wire [PA_W-1:0] ram_pa = paddr - `MBM_RAM_BASE;
  wire [16:0] xw_end = {1'b0, xbh_reg, xbl_reg} + {1'b0, xsh_reg, xsl_reg};
  wire in_xwin = (ram_pa[15:0] >= {xbh_reg, xbl_reg}) && ({1'b0, ram_pa[15:0]} < xw_end);
  reg op_ok, rg_ok;
  always @* begin
    // Operation kinds each memory supports
    case (rg)
      `MBM_RG_TROM, `MBM_RG_AROM: op_ok = (mem_op_i == `MBM_OP_RD) || (mem_op_i == `MBM_OP_EX);
      `MBM_RG_CLEE, `MBM_RG_AEE, `MBM_RG_MFG: op_ok = (mem_op_i != 2'h3);
      `MBM_RG_CLRAM, `MBM_RG_ARAM: op_ok = (mem_op_i == `MBM_OP_RD) || (mem_op_i == `MBM_OP_WR);
      default: op_ok = 1'b0;
    endcase
    case (mode)
      `MBM_MODE_TEST: rg_ok = (rg != `MBM_RG_NONE);
      `MBM_MODE_BOOT: rg_ok = (rg == `MBM_RG_TROM) || (rg == `MBM_RG_CLEE) ||
                              (rg == `MBM_RG_CLRAM) || (rg == `MBM_RG_MFG);
      `MBM_MODE_CLOS: rg_ok = (rg == `MBM_RG_TROM) || (rg == `MBM_RG_CLEE) ||
                              (rg == `MBM_RG_CLRAM) || ((rg == `MBM_RG_ARAM) && in_xwin);
      `MBM_MODE_SYS: rg_ok = (rg == `MBM_RG_AROM) || (rg == `MBM_RG_AEE) ||
                             (rg == `MBM_RG_ARAM);
      `MBM_MODE_USER: rg_ok = any_hit && hit_allow && ((rg == `MBM_RG_AROM) ||
                              (rg == `MBM_RG_AEE) || (rg == `MBM_RG_ARAM));
      default: rg_ok = 1'b0;
    endcase
  end
  wire mem_ok = op_ok && rg_ok;

  // Register access grant
  wire sfr_ok;
  mbmmu_sfr_guard u_guard (
    .mode_i(mode),
    .group_i(sfr_group_i),
    .we_i(sfr_we_i),
    .status_reg_i(sfr_status_reg_i),
    .hw_idx_i(sfr_hw_idx_i),
    .seg_rights_i(seg_rights[act_seg_reg]),
    .fw_rd_i(fwl_reg),
    .fw_wr_i(fwh_reg),
    .grant_o(sfr_ok)
  );

  // CPU side pipeline
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_gnt_o <= 1'b0;
      mem_deny_o <= 1'b0;
      mem_paddr_o <= {PA_W{1'b0}};
      mem_op_o <= 2'h0;
      act_seg_reg <= 6'h00;
      cpu_mode_o <= `MBM_MODE_BOOT;
      sfr_re_o <= 1'b0;
      sfr_we_o <= 1'b0;
      sfr_wdata_o <= 8'h00;
      rd_pend <= 1'b0;
      rd_gnt_reg <= 1'b0;
      cpu_rdata_o <= 8'h00;
      sfr_done_o <= 1'b0;
      sfr_deny_o <= 1'b0;
    end else begin
      cpu_mode_o <= mode;
      mem_gnt_o <= mem_req_i && mem_ok;
      mem_deny_o <= mem_req_i && !mem_ok;
      if (mem_req_i && mem_ok) begin
        mem_paddr_o <= paddr;
        mem_op_o <= mem_op_i;
      end
      if (mem_req_i && mem_ok && (mem_op_i == `MBM_OP_EX) && any_hit)
        act_seg_reg <= hit_idx;
      sfr_re_o <= sfr_req_i && !sfr_we_i && sfr_ok;
      sfr_we_o <= sfr_req_i && sfr_we_i && sfr_ok;
      if (sfr_req_i && sfr_we_i && sfr_ok)
        sfr_wdata_o <= sfr_wdata_i;
      rd_pend <= sfr_req_i;
      rd_gnt_reg <= sfr_req_i && sfr_ok;
      sfr_done_o <= rd_pend;
      if (rd_pend)
        cpu_rdata_o <= sfr_re_o ? sfr_rdata_i : 8'h00;
      if (rd_pend)
        sfr_deny_o <= !rd_gnt_reg;
      else
        sfr_deny_o <= 1'b0;
    end
  end

  // AXI4-Lite write path
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  wire aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  wire w_fire = s_axi_wvalid_i && s_axi_wready_o;
  wire [11:0] wa = aw_held ? awaddr_reg : s_axi_awaddr_i;
  wire [31:0] wd = w_held ? wdata_reg : s_axi_wdata_i;
  wire [3:0] ws = w_held ? wstrb_reg : s_axi_wstrb_i;
  wire do_wr = (aw_held || aw_fire) && (w_held || w_fire) && !s_axi_bvalid_o;
  wire [31:0] wm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire [5:0] widx = wa[9:4];
  wire wseg = (wa[11:10] == 2'b01);

  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && ((a[11:10] == 2'b01) || (a <= `MBM_OFF_STAT));
    end
  endfunction

  wire mem_deny_evt = mem_req_i && !mem_ok;
  wire sfr_deny_evt = sfr_req_i && !sfr_ok;
  wire stat_clr = do_wr && (wa == `MBM_OFF_STAT) && ws[2] && wd[`MBM_STAT_DENY];

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'h0;
      ctrl_reg <= `MBM_RST_CTRL;
      table_ptr_o <= `MBM_RST_TPTR;
      fwl_reg <= `MBM_RST_FW;
      fwh_reg <= `MBM_RST_FW;
      xbl_reg <= `MBM_RST_XW;
      xbh_reg <= `MBM_RST_XW;
      xsl_reg <= `MBM_RST_XW;
      xsh_reg <= `MBM_RST_XW;
      deny_reg <= 1'b0;
      for (j = 0; j < NSEG; j = j + 1) begin
        seg_rights[j] <= 8'h00;
        seg_first[j] <= {VA_W{1'b0}};
        seg_last[j] <= {VA_W{1'b0}};
        seg_offs[j] <= {PA_W{1'b0}};
      end
    end else begin
      if (aw_fire && !do_wr) begin
        aw_held <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (w_fire && !do_wr) begin
        w_held <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= mapped(wa) ? 2'h0 : 2'h2;
        if (wseg && (wa[1:0] == 2'b00)) begin
          case (wa[3:2])
            `MBM_SEG_RIGHTS: seg_rights[widx] <= (seg_rights[widx] & ~wm[7:0]) | (wd[7:0] & wm[7:0]);
            `MBM_SEG_FIRST: seg_first[widx] <= (seg_first[widx] & ~wm[VA_W-1:0]) |
                                               (wd[VA_W-1:0] & wm[VA_W-1:0]);
            `MBM_SEG_LAST: seg_last[widx] <= (seg_last[widx] & ~wm[VA_W-1:0]) |
                                             (wd[VA_W-1:0] & wm[VA_W-1:0]);
            `MBM_SEG_OFFS: seg_offs[widx] <= (seg_offs[widx] & ~wm[PA_W-1:0]) |
                                             (wd[PA_W-1:0] & wm[PA_W-1:0]);
            default: ;
          endcase
        end else if (ws[0]) begin
          case (wa)
            `MBM_OFF_CTRL: ctrl_reg <= wd[1:0];
            `MBM_OFF_FWL: fwl_reg <= wd[7:0];
            `MBM_OFF_FWH: fwh_reg <= wd[7:0];
            `MBM_OFF_XBL: xbl_reg <= wd[7:0];
            `MBM_OFF_XBH: xbh_reg <= wd[7:0];
            `MBM_OFF_XSL: xsl_reg <= wd[7:0];
            `MBM_OFF_XSH: xsh_reg <= wd[7:0];
            default: ;
          endcase
        end
        if (wa == `MBM_OFF_TPTR)
          table_ptr_o <= (table_ptr_o & ~wm[PA_W-1:0]) | (wd[PA_W-1:0] & wm[PA_W-1:0]);
      end else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
      // Denial flag, a new denial wins over the clear
      if (mem_deny_evt || sfr_deny_evt)
        deny_reg <= 1'b1;
      else if (stat_clr)
        deny_reg <= 1'b0;
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready_o = !s_axi_rvalid_o;
  wire [11:0] ra = s_axi_araddr_i;
  wire [5:0] ridx = ra[9:4];
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (ra[11:10] == 2'b01) begin
      case (ra[3:2])
        `MBM_SEG_RIGHTS: rd_mux = {24'h000000, seg_rights[ridx]};
        `MBM_SEG_FIRST: rd_mux = {{(32-VA_W){1'b0}}, seg_first[ridx]};
        `MBM_SEG_LAST: rd_mux = {{(32-VA_W){1'b0}}, seg_last[ridx]};
        default: rd_mux = {{(32-PA_W){1'b0}}, seg_offs[ridx]};
      endcase
    end else begin
      case (ra)
        `MBM_OFF_CTRL: rd_mux = {30'h0, ctrl_reg};
        `MBM_OFF_TPTR: rd_mux = {{(32-PA_W){1'b0}}, table_ptr_o};
        `MBM_OFF_FWL: rd_mux = {24'h000000, fwl_reg};
        `MBM_OFF_FWH: rd_mux = {24'h000000, fwh_reg};
        `MBM_OFF_XBL: rd_mux = {24'h000000, xbl_reg};
        `MBM_OFF_XBH: rd_mux = {24'h000000, xbh_reg};
        `MBM_OFF_XSL: rd_mux = {24'h000000, xsl_reg};
        `MBM_OFF_XSH: rd_mux = {24'h000000, xsh_reg};
        `MBM_OFF_STAT: rd_mux = {15'h0, deny_reg, 6'h00, act_seg_reg, 1'b0, mode};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= 2'h0;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= mapped(ra) ? rd_mux : 32'h00000000;
      s_axi_rresp_o <= mapped(ra) ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end
endmodule // mbmmu_top

//--- mbmmu_top_asserts.sv
// Port checker of the access-control unit.
// Assumes one clock and the top module's port names.
`timescale 1ns/1ps
`include "mbmmu_consts.vh"
module mbmmu_chk (
  input logic core_clk_i,
  input logic reset_n_i,
  input logic mem_req_i,
  input logic [1:0] mem_op_i,
  input logic mem_gnt_o,
  input logic mem_deny_o,
  input logic [1:0] mem_op_o,
  input logic sfr_req_i,
  input logic sfr_we_i,
  input logic [2:0] sfr_group_i,
  input logic [7:0] program_status_high_i,
  input logic sfr_re_o,
  input logic sfr_we_o,
  input logic sfr_done_o,
  input logic sfr_deny_o,
  input logic [7:0] cpu_rdata_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence sfr_gnt_s; sfr_req_i ##1 (sfr_re_o || sfr_we_o); endsequence
  sequence sfr_blk_s; sfr_req_i ##1 !(sfr_re_o || sfr_we_o); endsequence
  mem_answer_a: assert property (mem_req_i |=> mem_gnt_o != mem_deny_o)
    else $error("memory request without single answer");
  mem_quiet_a: assert property (!mem_req_i |=> !mem_gnt_o && !mem_deny_o)
    else $error("memory answer without request");
  mem_op_a: assert property (mem_gnt_o |-> mem_op_o == $past(mem_op_i))
    else $error("granted operation differs from request");
  deny_zero_a: assert property (sfr_done_o && sfr_deny_o |-> cpu_rdata_o == 8'h00)
    else $error("denied read returned data");
  sfr_grant_a: assert property (sfr_gnt_s |=> sfr_done_o && !sfr_deny_o)
    else $error("strobed access not completed as granted");
  sfr_drop_a: assert property (sfr_blk_s |=> sfr_done_o && sfr_deny_o)
    else $error("blocked access not reported as denied");
  cpu_group_a: assert property (sfr_req_i && sfr_group_i == `MBM_GRP_CPU
    |=> sfr_we_o == $past(sfr_we_i) && sfr_re_o != sfr_we_o) else $error("cpu register refused");
  seg_cfg_a: assert property (sfr_req_i && sfr_group_i == `MBM_GRP_SEGCFG
    && !program_status_high_i[`MBM_PROGRAM_STATUS_HIGH_SYS] |=> !sfr_re_o && !sfr_we_o)
    else $error("segment configuration reached outside system mode");
endmodule // mbmmu_chk
bind mbmmu_top mbmmu_chk u_chk (.core_clk_i, .reset_n_i, .mem_req_i, .mem_op_i, .mem_gnt_o,
  .mem_deny_o, .mem_op_o, .sfr_req_i, .sfr_we_i, .sfr_group_i, .program_status_high_i,
  .sfr_re_o, .sfr_we_o, .sfr_done_o, .sfr_deny_o, .cpu_rdata_o);

//--- mbmmu_sfr_file.sv
// Register file model behind the guard: one byte cell.
// Assumes single cycle strobes from the guard.
`timescale 1ns/1ps
module mbmmu_sfr_file (
  input logic clk_i,
  input logic reset_n_i,
  input logic re_i,
  input logic we_i,
  input logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] cell_reg;
  // Inverse outside a read strobe so stale data never looks valid
  assign rdata_o = re_i ? cell_reg : ~cell_reg;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cell_reg <= 8'h5a;
    else if (we_i) cell_reg <= wdata_i;
  end
endmodule // mbmmu_sfr_file

//--- mbmmu_top_test.sv
// Self-checking bench of the access-control unit.
// Assumes the register file model and the checker bound to the top.
`timescale 1ns/1ps
`include "mbmmu_consts.vh"
module mbmmu_top_test;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic mem_req_i = 1'b0, sfr_req_i = 1'b0, sfr_we_i = 1'b0, sfr_status_reg_i = 1'b0;
  logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic [7:0] program_status_high_i = 8'h00, sfr_wdata_i = 8'h00;
  logic [1:0] mem_op_i = 2'h0;
  logic [15:0] mem_vaddr_i = 16'h0;
  logic [2:0] sfr_group_i = 3'h0, sfr_hw_idx_i = 3'h0;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire mem_gnt_o, mem_deny_o, sfr_re_o, sfr_we_o, sfr_done_o, sfr_deny_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o, mem_op_o;
  wire [31:0] s_axi_rdata_o;
  wire [19:0] mem_paddr_o, table_ptr_o;
  wire [7:0] sfr_rdata_i, sfr_wdata_o, cpu_rdata_o;
  wire [2:0] cpu_mode_o;
  integer num_errors = 0;
  integer samples_checked = 0;
  always #10 core_clk_i = ~core_clk_i;
  mbmmu_top uut (.core_clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .program_status_high_i,
    .mem_req_i, .mem_op_i, .mem_vaddr_i, .mem_gnt_o, .mem_deny_o, .mem_paddr_o, .mem_op_o,
    .sfr_req_i, .sfr_we_i, .sfr_group_i, .sfr_hw_idx_i, .sfr_status_reg_i, .sfr_wdata_i,
    .sfr_rdata_i, .sfr_re_o, .sfr_we_o, .sfr_wdata_o, .cpu_rdata_o, .sfr_done_o, .sfr_deny_o,
    .cpu_mode_o, .table_ptr_o);
  mbmmu_sfr_file u_file (.clk_i(core_clk_i), .reset_n_i, .re_i(sfr_re_o), .we_i(sfr_we_o),
    .wdata_i(sfr_wdata_o), .rdata_o(sfr_rdata_i));
  task summarize;
    begin
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        num_errors++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task axi_wr(input logic [11:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge core_clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      n = 0;
      do begin
        @(posedge core_clk_i);
        n++;
        if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
        if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (!s_axi_bvalid_o && n < 50);
      s_axi_bready_i <= 1'b0;
      if (n >= 50) begin
        num_errors++;
        summarize;
      end
      chk(32'(s_axi_bresp_o), 32'h0);
    end
  endtask
  task axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    integer n;
    begin
      @(posedge core_clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      n = 0;
      do begin
        @(posedge core_clk_i);
        n++;
        if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (!s_axi_rvalid_o && n < 50);
      s_axi_rready_i <= 1'b0;
      if (n >= 50) begin
        num_errors++;
        summarize;
      end
      chk(s_axi_rdata_o, e);
      chk(32'(s_axi_rresp_o), 32'(er));
    end
  endtask
  task mem(input logic [1:0] op, input logic [15:0] va, input logic g, input logic [19:0] pa);
    begin
      @(posedge core_clk_i);
      mem_req_i <= 1'b1;
      mem_op_i <= op;
      mem_vaddr_i <= va;
      @(posedge core_clk_i);
      mem_req_i <= 1'b0;
      #1 chk(32'({mem_gnt_o, mem_deny_o}), 32'({g, !g}));
      if (g) chk(32'(mem_paddr_o), 32'(pa));
    end
  endtask
  task sfr(input logic we, input logic [2:0] grp, input logic [2:0] idx, input logic [7:0] wd,
    input logic dn, input logic [7:0] rd);
    begin
      @(posedge core_clk_i);
      sfr_req_i <= 1'b1;
      sfr_we_i <= we;
      sfr_group_i <= grp;
      sfr_hw_idx_i <= idx;
      sfr_wdata_i <= wd;
      @(posedge core_clk_i);
      sfr_req_i <= 1'b0;
      @(posedge core_clk_i);
      #1 chk(32'({sfr_done_o, sfr_deny_o, cpu_rdata_o}), 32'({1'b1, dn, rd}));
    end
  endtask
  task mode(input logic [7:0] psw, input logic [2:0] m);
    begin
      @(posedge core_clk_i);
      program_status_high_i <= psw;
      @(posedge core_clk_i);
      #1 chk(32'(cpu_mode_o), 32'(m));
    end
  endtask
  task regs_test;
    begin
      axi_rd(`MBM_OFF_CTRL, 32'h1, 2'h0);
      axi_wr(`MBM_OFF_TPTR, 32'h12345);
      axi_rd(`MBM_OFF_TPTR, 32'h12345, 2'h0);
      chk(32'(table_ptr_o), 32'h12345);
      axi_rd(12'h100, 32'h0, 2'h2);
    end
  endtask
  task boot_test;
    begin
      mode(8'h00, `MBM_MODE_BOOT);
      mem(`MBM_OP_RD, 16'h0100, 1'b1, 20'h00100);
      mem(`MBM_OP_WR, 16'h0100, 1'b0, 20'h0);
      mem(`MBM_OP_RD, 16'h8000, 1'b0, 20'h0);
    end
  endtask
  task user_test;
    begin
      axi_wr(`MBM_OFF_SEG, 32'h0d);
      axi_wr(`MBM_OFF_SEG + 12'h004, 32'h1000);
      axi_wr(`MBM_OFF_SEG + 12'h008, 32'h1fff);
      axi_wr(`MBM_OFF_SEG + 12'h00c, 32'h08000);
      axi_wr(`MBM_OFF_SEG + 12'h014, 32'h2000);
      axi_wr(`MBM_OFF_SEG + 12'h018, 32'h2fff);
      axi_wr(`MBM_OFF_CTRL, 32'h0);
      mode(8'h00, `MBM_MODE_USER);
      mem(`MBM_OP_RD, 16'h1000, 1'b1, 20'h09000);
      mem(`MBM_OP_RD, 16'h1fff, 1'b1, 20'h09fff);
      mem(`MBM_OP_WR, 16'h1000, 1'b0, 20'h0);
      mem(`MBM_OP_RD, 16'h2000, 1'b0, 20'h0);
      mem(`MBM_OP_RD, 16'h3000, 1'b0, 20'h0);
      mem(`MBM_OP_EX, 16'h1800, 1'b1, 20'h09800);
      sfr(1'b0, `MBM_GRP_HW, 3'h0, 8'h00, 1'b0, 8'h5a);
      sfr(1'b1, `MBM_GRP_HW, 3'h0, 8'h33, 1'b1, 8'h00);
      sfr(1'b0, `MBM_GRP_SEGCFG, 3'h0, 8'h00, 1'b1, 8'h00);
      sfr(1'b0, `MBM_GRP_CPU, 3'h0, 8'h00, 1'b0, 8'h5a);
    end
  endtask
  task sys_os_test;
    begin
      mode(8'h10, `MBM_MODE_SYS);
      sfr(1'b1, `MBM_GRP_SEGCFG, 3'h0, 8'h77, 1'b0, 8'h00);
      sfr(1'b0, `MBM_GRP_SEGCFG, 3'h0, 8'h00, 1'b0, 8'h77);
      axi_wr(`MBM_OFF_FWL, 32'h1);
      mode(8'h08, `MBM_MODE_CLOS);
      sfr(1'b0, `MBM_GRP_HW, 3'h0, 8'h00, 1'b0, 8'h77);
      sfr(1'b0, `MBM_GRP_HW, 3'h1, 8'h00, 1'b1, 8'h00);
      sfr(1'b1, `MBM_GRP_HW, 3'h0, 8'h11, 1'b1, 8'h00);
      mem(`MBM_OP_RD, 16'h0010, 1'b1, 20'h00010);
      mem(`MBM_OP_RD, 16'h8000, 1'b0, 20'h0);
      axi_rd(`MBM_OFF_STAT, 32'h00010002, 2'h0);
      axi_wr(`MBM_OFF_STAT, 32'h00010000);
      axi_rd(`MBM_OFF_STAT, 32'h00000002, 2'h0);
      axi_wr(`MBM_OFF_CTRL, 32'h2);
      mode(8'h00, `MBM_MODE_TEST);
      mem(`MBM_OP_RD, 16'h8000, 1'b1, 20'h08000);
      sfr(1'b0, `MBM_GRP_TEST, 3'h0, 8'h00, 1'b0, 8'h77);
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    regs_test;
    boot_test;
    user_test;
    sys_os_test;
    summarize;
  end
endmodule // mbmmu_top_test
